// File: inc/part_id_pkg.sv
// package: map, field layout and carriers of the part identification bank
package part_id_pkg;

    // memory-mapped byte addresses
    localparam logic [31:0] ADDR_LOT_SERIAL   = 32'hFFFF0238;
    localparam logic [31:0] ADDR_PART_REV     = 32'hFFFF023C;
    localparam logic [31:0] ADDR_ASM_LOW      = 32'hFFFF0560;
    localparam logic [31:0] ADDR_TIMER_LOAD   = 32'hFFFF0320;
    localparam logic [31:0] ADDR_FAMILY       = 32'hFFFF0E10;

    // reset values before the power-on load
    localparam logic [31:0] LOT_SERIAL_RST    = 32'h00000000;
    localparam logic [31:0] PART_REV_RST      = 32'h00000000;
    localparam logic [31:0] ASM_LOW_RST       = 32'h00000000;
    localparam logic [31:0] TIMER_LOAD_RST    = 32'h00000000;
    localparam logic [15:0] FAMILY_RST        = 16'h0000;

    // field positions
    localparam int WAFER_MSB   = 31;
    localparam int WAFER_LSB   = 27;
    localparam int PLANT_MSB   = 26;
    localparam int PLANT_LSB   = 22;
    localparam int FABHI_MSB   = 21;
    localparam int FABHI_LSB   = 16;
    localparam int LOTNUM_MSB  = 15;
    localparam int MASK_MSB    = 31;
    localparam int MASK_LSB    = 28;
    localparam int KREV_MSB    = 27;
    localparam int KREV_LSB    = 20;
    localparam int KMINOR_MSB  = 19;
    localparam int KMINOR_LSB  = 16;
    localparam int PARTID_MSB  = 15;
    localparam int FAMID_MSB   = 3;

    // legal field ranges
    localparam logic [4:0] WAFER_MIN   = 5'h01;
    localparam logic [4:0] WAFER_MAX   = 5'h18;
    localparam logic [3:0] MASK_MIN    = 4'h1;
    localparam logic [3:0] ASCII_UPPER = 4'h4;

    typedef enum logic [1:0] {
        ST_LOAD = 2'b01,
        ST_RUN  = 2'b10
    } id_state_t;

    // traceability image handed over by the kernel at power-on
    typedef struct packed {
        logic        prerelease;
        logic [31:0] lot_serial;
        logic [31:0] part_rev;
        logic [31:0] asm_low;
        logic [31:0] asm_high;
        logic [15:0] family;
    } trace_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [31:0] addr;
        logic [31:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic [31:0] lot_serial;
        logic [31:0] part_rev;
        logic [31:0] asm_low;
        logic [31:0] timer_load;
        logic [15:0] family;
    } id_regs_t;

endpackage : part_id_pkg

// File: hw/part_id_bank.sv
// part identification register bank with power-on load and register access
// Functional notes
// [R1] both serial registers loaded after power-on
// [R2] lot serial top five bits: wafer 1..24
// [R3] lot serial bits 26:22: fabrication plant
// [R4] lot serial bits 21:16: upper lot id
// [R5] lot serial low 16 bits: lot number
// [R6] revision top nibble: mask revision 1..15
// [R7] revision bits 27:20: kernel revision ascii
// [R8] bits 19:16 zero unless prerelease sample
// [R9] revision low 16 bits: part id
// [R10] assembly lot low half in register
// [R11] timer load holds assembly lot high half
// [R12] family register loaded at power-up
// [R13] values hold until software overwrites them
`timescale 1ns/1ps
module part_id_bank
    import part_id_pkg::*;
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST,
    // kernel traceability image
    input  wire trace_t      TRACE,
    // memory-mapped register access
    input  wire reg_req_t    REG_REQ,
    output logic [31:0]      REG_RDATA,
    output logic             REG_RVALID,
    // status
    output logic             ID_LOADED,
    output logic             ID_FAULT
);

    id_state_t   state;
    id_state_t   next_state;
    id_regs_t    regs;
    id_regs_t    next_regs;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        rvalid;
    logic        next_rvalid;
    logic        fault;
    logic        next_fault;

    // address decode to a register index; 0 means unmapped
    function automatic logic [2:0] decode(input logic [31:0] a);
        if (a == ADDR_LOT_SERIAL)
            decode = 3'h1;
        else if (a == ADDR_PART_REV)
            decode = 3'h2;
        else if (a == ADDR_ASM_LOW)
            decode = 3'h3;
        else if (a == ADDR_TIMER_LOAD)
            decode = 3'h4;
        else if (a == ADDR_FAMILY)
            decode = 3'h5;
        else
            decode = 3'h0;
    endfunction : decode

    // production parts keep the minor-revision field clear
    function automatic logic [31:0] rev_clean(input logic [31:0] v,
                                              input logic pre);
        rev_clean = v;
        if (!pre)
        begin
            rev_clean[KMINOR_MSB:KMINOR_LSB] = 4'h0;
        end
    endfunction : rev_clean

    // identity sanity: wafer 1..24 and mask revision 1..15
    function automatic logic bad_id(input id_regs_t r);
        logic [4:0] w;
        logic [3:0] m;
        w = r.lot_serial[WAFER_MSB:WAFER_LSB];
        m = r.part_rev[MASK_MSB:MASK_LSB];
        bad_id = (w < WAFER_MIN) || (w > WAFER_MAX) || (m < MASK_MIN);
    endfunction : bad_id

    always_comb
    begin
        next_state  = state;
        next_regs   = regs;
        next_rdata  = rdata;
        next_rvalid = 1'b0;
        case (state)
            ST_LOAD:
            begin
                // one-shot image load, bus traffic is ignored meanwhile
                next_regs.lot_serial = TRACE.lot_serial; // R1 R2 R3 R4 R5
                next_regs.part_rev   =
                    rev_clean(TRACE.part_rev, TRACE.prerelease); // R6 R7 R8 R9
                next_regs.asm_low    = TRACE.asm_low;    // R10
                next_regs.timer_load = TRACE.asm_high;   // R11
                next_regs.family     = TRACE.family;     // R12
                next_state           = ST_RUN;
            end
            ST_RUN:
            begin
                // only a software write changes a register after load
                if (REG_REQ.wr) // R13
                begin
                    case (decode(REG_REQ.addr))
                        3'h1: next_regs.lot_serial = REG_REQ.wdata;
                        3'h2: next_regs.part_rev   = REG_REQ.wdata;
                        3'h3: next_regs.asm_low    = REG_REQ.wdata;
                        3'h4: next_regs.timer_load = REG_REQ.wdata;
                        3'h5: next_regs.family     = REG_REQ.wdata[15:0];
                        default: next_regs = regs;
                    endcase
                end
                if (REG_REQ.rd)
                begin
                    next_rvalid = 1'b1;
                    case (decode(REG_REQ.addr))
                        3'h1: next_rdata = regs.lot_serial;
                        3'h2: next_rdata = regs.part_rev;
                        3'h3: next_rdata = regs.asm_low;
                        3'h4: next_rdata = regs.timer_load;
                        3'h5: next_rdata = {16'h0000, regs.family};
                        default: next_rdata = 32'h00000000;
                    endcase
                end
            end
            default:
            begin
                next_state = ST_LOAD;
            end
        endcase
        next_fault = bad_id(next_regs);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            state            <= ST_LOAD;
            regs.lot_serial  <= LOT_SERIAL_RST;
            regs.part_rev    <= PART_REV_RST;
            regs.asm_low     <= ASM_LOW_RST;
            regs.timer_load  <= TIMER_LOAD_RST;
            regs.family      <= FAMILY_RST;
            rdata            <= 32'h00000000;
            rvalid           <= 1'b0;
            fault            <= 1'b0;
        end
        else
        begin
            state  <= next_state;
            regs   <= next_regs;
            rdata  <= next_rdata;
            rvalid <= next_rvalid;
            fault  <= next_fault;
        end
    end

    assign REG_RDATA  = rdata;
    assign REG_RVALID = rvalid;
    assign ID_LOADED  = (state == ST_RUN);
    assign ID_FAULT   = fault;

    logic req_lot;
    logic req_rev;
    logic rd_taken;
    logic wr_timer;
    assign req_lot  = REG_REQ.rd && (REG_REQ.addr == ADDR_LOT_SERIAL);
    assign req_rev  = REG_REQ.rd && (REG_REQ.addr == ADDR_PART_REV);
    assign rd_taken = REG_REQ.rd && ID_LOADED;
    assign wr_timer = REG_REQ.wr && (REG_REQ.addr == ADDR_TIMER_LOAD);

    property p_reset_default;
        @(posedge CLK) disable iff (RST)
        (state == ST_LOAD) |-> (regs.lot_serial == LOT_SERIAL_RST)
            && (regs.part_rev == PART_REV_RST);
    endproperty
    a_reset_default: assert property (p_reset_default) // R1
        else $error("serial registers not at default before load");

    property p_lot_load;
        @(posedge CLK) disable iff (RST)
        (state == ST_LOAD) |=> (regs.lot_serial == $past(TRACE.lot_serial))
            && ID_LOADED;
    endproperty
    a_lot_load: assert property (p_lot_load) // R1
        else $error("lot serial not loaded from image");

    property p_wafer_range;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && !ID_FAULT |->
            (regs.lot_serial[WAFER_MSB:WAFER_LSB]
                inside {[WAFER_MIN:WAFER_MAX]})
            && (regs.part_rev[MASK_MSB:MASK_LSB] != 4'h0);
    endproperty
    a_wafer_range: assert property (p_wafer_range) // R2
        else $error("wafer or mask out of range without fault");

    property p_lot_fields;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && req_lot |=> REG_RVALID
            && (REG_RDATA[PLANT_MSB:PLANT_LSB]
                == $past(regs.lot_serial[PLANT_MSB:PLANT_LSB]))
            && (REG_RDATA[FABHI_MSB:FABHI_LSB]
                == $past(regs.lot_serial[FABHI_MSB:FABHI_LSB]))
            && (REG_RDATA[LOTNUM_MSB:0]
                == $past(regs.lot_serial[LOTNUM_MSB:0]));
    endproperty
    a_lot_fields: assert property (p_lot_fields) // R3
        else $error("lot serial fields read back wrong");

    property p_rev_fields;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && req_rev |=> REG_RVALID
            && (REG_RDATA[KREV_MSB:KREV_LSB]
                == $past(regs.part_rev[KREV_MSB:KREV_LSB]))
            && (REG_RDATA[MASK_MSB:MASK_LSB]
                == $past(regs.part_rev[MASK_MSB:MASK_LSB]));
    endproperty
    a_rev_fields: assert property (p_rev_fields) // R7
        else $error("revision fields read back wrong");

    property p_wafer_read;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && req_lot |=> REG_RVALID
            && (REG_RDATA[WAFER_MSB:WAFER_LSB]
                == $past(regs.lot_serial[WAFER_MSB:WAFER_LSB]));
    endproperty
    a_wafer_read: assert property (p_wafer_read) // R2
        else $error("wafer number read back wrong");

    property p_part_id;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && req_rev |=> REG_RVALID
            && (REG_RDATA[PARTID_MSB:0] == $past(regs.part_rev[PARTID_MSB:0]))
            && (REG_RDATA[KMINOR_MSB:KMINOR_LSB]
                == $past(regs.part_rev[KMINOR_MSB:KMINOR_LSB]));
    endproperty
    a_part_id: assert property (p_part_id) // R9
        else $error("part id or minor field read back wrong");

    // fault must track both range limits, not only the wafer field
    property p_fault_flag;
        @(posedge CLK) disable iff (RST)
        ID_LOADED |-> ID_FAULT
            == (!(regs.lot_serial[WAFER_MSB:WAFER_LSB]
                  inside {[WAFER_MIN:WAFER_MAX]})
                || (regs.part_rev[MASK_MSB:MASK_LSB] == 4'h0));
    endproperty
    a_fault_flag: assert property (p_fault_flag) // R6
        else $error("fault flag disagrees with stored identity");

    property p_minor_clear;
        @(posedge CLK) disable iff (RST)
        (state == ST_LOAD) && !TRACE.prerelease |=>
            (regs.part_rev[KMINOR_MSB:KMINOR_LSB] == 4'h0)
            && (regs.part_rev[PARTID_MSB:0]
                == $past(TRACE.part_rev[PARTID_MSB:0]));
    endproperty
    a_minor_clear: assert property (p_minor_clear) // R8
        else $error("minor revision not cleared on production part");

    property p_asm_load;
        @(posedge CLK) disable iff (RST)
        (state == ST_LOAD) |=> (regs.asm_low == $past(TRACE.asm_low))
            && (regs.timer_load == $past(TRACE.asm_high))
            && (regs.family == $past(TRACE.family));
    endproperty
    a_asm_load: assert property (p_asm_load) // R10
        else $error("assembly lot or family not loaded");

    property p_hold;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && !REG_REQ.wr |=> $stable(regs);
    endproperty
    a_hold: assert property (p_hold) // R13
        else $error("identification changed without a write");

    property p_unmapped;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && REG_REQ.rd && (decode(REG_REQ.addr) == 3'h0)
            |=> REG_RVALID && (REG_RDATA == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    property p_minor_keep;
        @(posedge CLK) disable iff (RST)
        (state == ST_LOAD) && TRACE.prerelease
            |=> (regs.part_rev == $past(TRACE.part_rev));
    endproperty
    a_minor_keep: assert property (p_minor_keep) // R8
        else $error("prerelease minor revision not kept");

    property p_timer_write;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && wr_timer |=> (regs.timer_load == $past(REG_REQ.wdata));
    endproperty
    a_timer_write: assert property (p_timer_write) // R11
        else $error("timer load write not taken");

    property p_family_read;
        @(posedge CLK) disable iff (RST)
        ID_LOADED && REG_REQ.rd && (REG_REQ.addr == ADDR_FAMILY)
            |=> REG_RVALID && (REG_RDATA == {16'h0000, $past(regs.family)});
    endproperty
    a_family_read: assert property (p_family_read) // R12
        else $error("family register read back wrong");

    // one answer per taken read, none for requests dropped during load
    property p_rvalid_pulse;
        @(posedge CLK) disable iff (RST)
        REG_RVALID == $past(rd_taken);
    endproperty
    a_rvalid_pulse: assert property (p_rvalid_pulse)
        else $error("read valid not paired with a taken read");

    c_load: cover property (@(posedge CLK) disable iff (RST)
        (state == ST_LOAD) ##1 ID_LOADED);
    c_read_rev: cover property (@(posedge CLK) disable iff (RST)
        ID_LOADED && req_rev ##1 REG_RVALID);
    c_write_timer: cover property (@(posedge CLK) disable iff (RST)
        ID_LOADED && wr_timer);
    c_fault: cover property (@(posedge CLK) disable iff (RST)
        ID_LOADED && ID_FAULT);
    c_prerelease: cover property (@(posedge CLK) disable iff (RST)
        (state == ST_LOAD) && TRACE.prerelease ##1 ID_LOADED);

endmodule : part_id_bank

// File: tb/test_part_id_bank.sv
// self-checking bench for the part identification register bank
`timescale 1ns/1ps
module test_part_id_bank;
    import part_id_pkg::*;

    logic        clk          = 1'b0;
    logic        rst          = 1'b1;
    trace_t      trace        = '0;
    reg_req_t    req          = '0;
    logic [31:0] rdata;
    logic        rvalid;
    logic        loaded;
    logic        fault;
    logic [31:0] seed         = 32'h75AD;
    logic [31:0] expq[$];
    logic [31:0] regs[5];
    logic [31:0] addrs[5];
    int          mismatches   = 0;
    int          total_checks = 0;
    trace_t      img;

    always #4 clk = ~clk;

    part_id_bank u_part_id_bank (
        .CLK        (clk),
        .RST        (rst),
        .TRACE      (trace),
        .REG_REQ    (req),
        .REG_RDATA  (rdata),
        .REG_RVALID (rvalid),
        .ID_LOADED  (loaded),
        .ID_FAULT   (fault)
    );

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // a read answer with nothing queued must still count as a mismatch
    always @(posedge clk)
        if (rvalid === 1'b1)
            check(rdata, expq.size() > 0 ? expq.pop_front()
                                         : ((rdata === 32'h0) ? 32'h1 : 32'h0));

    function automatic trace_t mk(input logic pre, input logic [4:0] wafer,
                                  input logic [3:0] mask);
        trace_t      t;
        logic [31:0] a;
        logic [31:0] b;
        a = rnd();
        b = rnd();
        t.prerelease = pre;
        t.lot_serial = {wafer, a[26:0]};
        t.part_rev   = {mask, b[27:0]};
        t.asm_low    = rnd();
        t.asm_high   = rnd();
        t.family     = a[15:0] ^ b[31:16];
        return t;
    endfunction : mk

    // one request per cycle; fields change only 1 ns after an edge
    task automatic acc(input logic r, input logic w, input logic [31:0] a,
                       input logic [31:0] d, input logic [31:0] e);
        req = '{rd: r, wr: w, addr: a, wdata: d};
        if (r)
            expq.push_back(e);
        @(posedge clk);
        #1;
    endtask : acc

    task automatic idle(input int n);
        req = '0;
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    task automatic do_reset(input trace_t t, input logic f);
        rst = 1'b1;
        trace = t;
        repeat (3) @(posedge clk);
        #1;
        check(rdata, 32'h0);
        check({30'h0, loaded, fault}, 32'h0);
        rst = 1'b0;
        @(posedge clk);
        #1;
        check({30'h0, loaded, fault}, {30'h0, 1'b1, f});
        trace = mk(1'b1, 5'h00, 4'h0);
        regs[0] = t.lot_serial;
        regs[1] = t.part_rev;
        if (!t.prerelease)
            regs[1][19:16] = 4'h0;
        regs[2] = t.asm_low;
        regs[3] = t.asm_high;
        regs[4] = {16'h0000, t.family};
    endtask : do_reset

    task automatic read_all();
        acc(1'b1, 1'b0, addrs[0], 32'h0, regs[0]);
        acc(1'b1, 1'b0, addrs[1], 32'h0, regs[1]);
        acc(1'b1, 1'b0, addrs[2], 32'h0, regs[2]);
        acc(1'b1, 1'b0, addrs[3], 32'h0, regs[3]);
        acc(1'b1, 1'b0, addrs[4], 32'h0, regs[4]);
        idle(2);
    endtask : read_all

    initial
    begin
        #200000;
        mismatches++;
        results();
    end

    initial
    begin
        logic [31:0] d;
        addrs = '{ADDR_LOT_SERIAL, ADDR_PART_REV, ADDR_ASM_LOW,
                  ADDR_TIMER_LOAD, ADDR_FAMILY};
        img = mk(1'b0, 5'h18, 4'hF);
        do_reset(img, 1'b0);
        read_all();
        $display("test load image done");
        // read and write in one cycle: old value out, new value kept
        for (int i = 0; i < 5; i++)
        begin
            d = rnd();
            acc(1'b1, 1'b1, addrs[i], d, regs[i]);
            regs[i] = (i == 4) ? {16'h0000, d[15:0]} : d;
            acc(1'b1, 1'b0, addrs[i], 32'h0, regs[i]);
        end
        acc(1'b0, 1'b1, 32'hFFFF0244, rnd(), 32'h0);
        acc(1'b1, 1'b0, 32'hFFFF0244, 32'h0, 32'h0);
        idle(20);
        read_all();
        $display("test writes done");
        for (int k = 0; k < 4; k++)
        begin
            case (k)
                0: img = mk(1'b1, 5'h00, 4'h1);
                1: img = mk(1'b0, 5'h19, 4'h1);
                2: img = mk(1'b1, 5'h01, 4'h0);
                default: img = mk(1'b1, 5'h01, 4'h1);
            endcase
            do_reset(img, k != 3);
            read_all();
        end
        acc(1'b0, 1'b1, ADDR_LOT_SERIAL, 32'h0, 32'h0);
        check({31'h0, fault}, 32'h1);
        idle(2);
        check(expq.size(), 32'h0);
        $display("test image ranges done");
        results();
    end

endmodule : test_part_id_bank
